// ### verilog/fhc_host.sv
// The implementer's own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/10ps
module fhc_host (
  input  wire logic                         ref_clk,
  input  wire logic                         srst,
  input  wire logic                         ce,
  input  wire logic                         hsel,
  input  wire logic [31:0]                  haddr,
  input  wire logic [1:0]                   htrans,
  input  wire logic                         hwrite,
  input  wire logic [2:0]                   hsize,
  input  wire logic [fhc_pkg::DATA_W-1:0]   hwdata,
  input  wire logic                         hready,
  output logic                              hreadyout,
  output logic                              hresp,
  output logic      [fhc_pkg::DATA_W-1:0]   hrdata,
  output fhc_pkg::fhc_dev_ctl_s             dev_ctl,
  input  wire fhc_pkg::fhc_dev_sts_s        dev_sts
);

  // ==========================================================
  // Pin synchronisers
  fhc_pkg::fhc_dev_sts_s sts_s;

  fhc_sync #(
    .W ($bits(fhc_pkg::fhc_dev_sts_s))
  ) u_sync (
    .ref_clk (ref_clk),
    .srst    (srst),
    .ce      (ce),
    .d       (dev_sts),
    .q       (sts_s)
  );

  // ==========================================================
  // Bus slave state
  logic                             pend_r,   pend_nxt;
  logic                             wr_r,     wr_nxt;
  logic [fhc_pkg::ADDR_W-1:0]       addr_r,   addr_nxt;
  logic                             hrdy_nxt;
  logic [fhc_pkg::DATA_W-1:0]       hrd_nxt;
  logic [fhc_pkg::WORD_W-1:0]       wdata_r,  wdata_nxt;
  logic [fhc_pkg::CFG_W-1:0]        cfg_r,    cfg_nxt;
  logic [fhc_pkg::CMD_W-1:0]        go_r,     go_nxt;
  logic [fhc_pkg::REF_W-1:0]        clr_r,    clr_nxt;

  // Sequencer state
  fhc_pkg::fhc_state_e              state_r,  state_nxt;
  fhc_pkg::fhc_cnt_t                cnt_r,    cnt_nxt;
  fhc_pkg::fhc_dev_ctl_s            ctl_nxt;
  logic                             init_r,   init_nxt;
  logic                             depth_r,  depth_nxt;
  logic                             first_r,  first_nxt;
  logic [fhc_pkg::WORD_W-1:0]       rdata_r,  rdata_nxt;
  logic [fhc_pkg::REF_W-1:0]        ref_r,    ref_nxt;
  logic [fhc_pkg::REF_W-1:0]        ref_set;
  logic [fhc_pkg::DATA_W-1:0]       status;

  function automatic logic is_last(input fhc_pkg::fhc_cnt_t cnt,
                                   input fhc_pkg::fhc_cnt_t lim);
    is_last = (cnt == lim - fhc_pkg::CNT_STEP);
  endfunction : is_last

  function automatic logic [fhc_pkg::DATA_W-1:0] rd_word(
    input logic [fhc_pkg::ADDR_W-1:0] a,
    input logic [fhc_pkg::WORD_W-1:0] wd,
    input logic [fhc_pkg::WORD_W-1:0] rd,
    input logic [fhc_pkg::DATA_W-1:0] st,
    input logic [fhc_pkg::CFG_W-1:0]  cf);
    rd_word = '0;
    case (a)
      fhc_pkg::REG_WDATA:  rd_word[fhc_pkg::WORD_W-1:0] = wd;
      fhc_pkg::REG_RDATA:  rd_word[fhc_pkg::WORD_W-1:0] = rd;
      fhc_pkg::REG_STATUS: rd_word = st;
      fhc_pkg::REG_CFG:    rd_word[fhc_pkg::CFG_W-1:0] = cf;
      default:             rd_word = '0;
    endcase
  endfunction : rd_word

  // ==========================================================
  // Status word; flags shown at pin level, after synchroniser
  always_comb begin
    status                             = '0;
    status[fhc_pkg::ST_BUSY]           = (state_r != fhc_pkg::S_IDLE);
    status[fhc_pkg::ST_INIT]           = init_r;
    status[fhc_pkg::ST_NODATA]         = sts_s.no_data_flag_n;
    status[fhc_pkg::ST_NOROOM]         = sts_s.no_room_flag_n;
    // Chain_out level when the device runs in depth mode
    status[fhc_pkg::ST_MID]            = sts_s.midpoint_flag_n;
    status[fhc_pkg::ST_RT_REF:fhc_pkg::ST_WR_REF] = ref_r;
  end

  // ==========================================================
  // AHB-Lite slave: one wait state on every transfer
  always_comb begin
    pend_nxt  = pend_r;
    wr_nxt    = wr_r;
    addr_nxt  = addr_r;
    hrdy_nxt  = hreadyout;
    hrd_nxt   = hrdata;
    wdata_nxt = wdata_r;
    cfg_nxt   = cfg_r;
    go_nxt    = '0;
    clr_nxt   = '0;
    if (pend_r) begin
      pend_nxt = 1'b0;
      hrdy_nxt = 1'b1;
      if (wr_r) begin
        case (addr_r)
          fhc_pkg::REG_CMD:    go_nxt = hwdata[fhc_pkg::CMD_W-1:0];
          fhc_pkg::REG_WDATA:  wdata_nxt = hwdata[fhc_pkg::WORD_W-1:0];
          fhc_pkg::REG_STATUS: clr_nxt =
            hwdata[fhc_pkg::ST_RT_REF:fhc_pkg::ST_WR_REF];
          fhc_pkg::REG_CFG:    cfg_nxt = hwdata[fhc_pkg::CFG_W-1:0];
          default:             go_nxt = '0;
        endcase
      end else begin
        hrd_nxt = rd_word(addr_r, wdata_r, rdata_r, status, cfg_r);
      end
    end else if (hsel && htrans[1] && hready) begin
      pend_nxt = 1'b1;
      hrdy_nxt = 1'b0;
      wr_nxt   = hwrite;
      addr_nxt = haddr[fhc_pkg::ADDR_W-1:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      pend_r    <= 1'b0;
      wr_r      <= 1'b0;
      addr_r    <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= '0;
      wdata_r   <= '0;
      cfg_r     <= fhc_pkg::CFG_RESET;
      go_r      <= '0;
      clr_r     <= '0;
    end else if (ce) begin
      pend_r    <= pend_nxt;
      wr_r      <= wr_nxt;
      addr_r    <= addr_nxt;
      hreadyout <= hrdy_nxt;
      hresp     <= 1'b0;
      hrdata    <= hrd_nxt;
      wdata_r   <= wdata_nxt;
      cfg_r     <= cfg_nxt;
      go_r      <= go_nxt;
      clr_r     <= clr_nxt;
    end
  end

  // ==========================================================
  // Pin sequencer; commands arriving while busy are dropped
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r + fhc_pkg::CNT_STEP;
    ctl_nxt   = dev_ctl;
    init_nxt  = init_r;
    depth_nxt = depth_r;
    first_nxt = first_r;
    rdata_nxt = rdata_r;
    ref_set   = '0;
    case (state_r)
      fhc_pkg::S_IDLE: begin
        cnt_nxt = '0;
        if (!init_r || go_r[fhc_pkg::CMD_RESET]) begin
          state_nxt             = fhc_pkg::S_RST;
          depth_nxt             = cfg_r[fhc_pkg::CFG_DEPTH];
          first_nxt             = cfg_r[fhc_pkg::CFG_FIRST];
          ctl_nxt.clear_pulse_n = 1'b0;
          // Mode level set up with the clear edge
          ctl_nxt.lead_or_replay_n =
            cfg_r[fhc_pkg::CFG_DEPTH] ? cfg_r[fhc_pkg::CFG_FIRST] : 1'b1;
        end else if (go_r[fhc_pkg::CMD_REPLAY]) begin
          // Depth mode keeps its lead level
          if (depth_r) begin
            ref_set[fhc_pkg::ST_RT_REF-fhc_pkg::ST_WR_REF] = 1'b1;
          end else begin
            state_nxt                = fhc_pkg::S_RT;
            ctl_nxt.lead_or_replay_n = 1'b0;
          end
        end else if (go_r[fhc_pkg::CMD_WRITE]) begin
          // Level test of the synchronised flag
          if (sts_s.no_room_flag_n) begin
            state_nxt             = fhc_pkg::S_WR;
            ctl_nxt.store_pulse_n = 1'b0;
            ctl_nxt.in_bus        = wdata_r;
          end else begin
            ref_set[0] = 1'b1;
          end
        end else if (go_r[fhc_pkg::CMD_READ]) begin
          if (sts_s.no_data_flag_n) begin
            state_nxt             = fhc_pkg::S_RD;
            ctl_nxt.fetch_pulse_n = 1'b0;
          end else begin
            ref_set[fhc_pkg::ST_RD_REF-fhc_pkg::ST_WR_REF] = 1'b1;
          end
        end
      end
      fhc_pkg::S_RST: begin
        if (is_last(cnt_r, fhc_pkg::RST_LOW_CYC)) begin
          // Strobes stay high through the recovery that follows
          ctl_nxt.clear_pulse_n = 1'b1;
          init_nxt              = 1'b1;
          state_nxt             = fhc_pkg::S_REC;
          cnt_nxt               = '0;
        end
      end
      fhc_pkg::S_WR: begin
        if (is_last(cnt_r, fhc_pkg::WR_LOW_CYC)) begin
          // in_bus left in place for hold time
          ctl_nxt.store_pulse_n = 1'b1;
          state_nxt             = fhc_pkg::S_REC;
          cnt_nxt               = '0;
        end
      end
      fhc_pkg::S_RD: begin
        if (is_last(cnt_r, fhc_pkg::RD_LOW_CYC)) begin
          ctl_nxt.fetch_pulse_n = 1'b1;
          rdata_nxt             = sts_s.out_bus;
          state_nxt             = fhc_pkg::S_REC;
          cnt_nxt               = '0;
        end
      end
      fhc_pkg::S_RT: begin
        if (is_last(cnt_r, fhc_pkg::RT_LOW_CYC)) begin
          ctl_nxt.lead_or_replay_n = 1'b1;
          state_nxt                = fhc_pkg::S_REC;
          cnt_nxt                  = '0;
        end
      end
      fhc_pkg::S_REC: begin
        if (is_last(cnt_r, fhc_pkg::REC_CYC)) begin
          state_nxt = fhc_pkg::S_IDLE;
        end
      end
      default: begin
        state_nxt = fhc_pkg::S_IDLE;
        ctl_nxt   = fhc_pkg::CTL_IDLE;
      end
    endcase
    // New refusal wins over a clear in the same cycle
    ref_nxt = (ref_r & ~clr_r) | ref_set;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      state_r <= fhc_pkg::S_IDLE;
      cnt_r   <= '0;
      dev_ctl <= fhc_pkg::CTL_IDLE;
      init_r  <= 1'b0;
      depth_r <= 1'b0;
      first_r <= 1'b0;
      rdata_r <= '0;
      ref_r   <= '0;
    end else if (ce) begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      // One controller drives a whole chain
      dev_ctl <= ctl_nxt;
      init_r  <= init_nxt;
      depth_r <= depth_nxt;
      first_r <= first_nxt;
      rdata_r <= rdata_nxt;
      ref_r   <= ref_nxt;
    end
  end

  // ==========================================================
  // Checks on the pins this block drives
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst || !ce);

  sequence s_strobes_high;
    dev_ctl.store_pulse_n && dev_ctl.fetch_pulse_n;
  endsequence

  sequence s_write_pulse;
    !dev_ctl.store_pulse_n [*4] ##1 dev_ctl.store_pulse_n;
  endsequence

  init_first_a: assert property (
    ($fell(dev_ctl.store_pulse_n) || $fell(dev_ctl.fetch_pulse_n))
    |-> init_r)
    else $error("Strobe before first reset cycle");

  rst_setup_a: assert property (
    !dev_ctl.clear_pulse_n |-> s_strobes_high)
    else $error("Strobe low while clear is low");

  rst_recovery_a: assert property (
    $rose(dev_ctl.clear_pulse_n) |-> s_strobes_high [*2])
    else $error("Strobe low inside reset recovery");

  rst_mode_a: assert property (
    !dev_ctl.clear_pulse_n |->
    dev_ctl.lead_or_replay_n == (depth_r ? first_r : 1'b1))
    else $error("Wrong mode level during reset");

  lead_hold_a: assert property (
    depth_r && dev_ctl.clear_pulse_n && $past(dev_ctl.clear_pulse_n)
    |-> $stable(dev_ctl.lead_or_replay_n))
    else $error("Lead level moved in depth mode");

  wr_pulse_a: assert property (
    $fell(dev_ctl.store_pulse_n) |-> s_write_pulse)
    else $error("Write strobe width wrong");

  wr_data_a: assert property (
    $fell(dev_ctl.store_pulse_n) |=> $stable(dev_ctl.in_bus) [*6])
    else $error("in_bus moved around write strobe");

  rt_strobe_a: assert property (
    $rose(dev_ctl.lead_or_replay_n) && !depth_r
    |-> $past(dev_ctl.store_pulse_n && dev_ctl.fetch_pulse_n)
    ##0 s_strobes_high [*7])
    else $error("Strobe active around replay pulse");

  flag_level_a: assert property (
    $fell(dev_ctl.store_pulse_n) |-> $past(sts_s.no_room_flag_n))
    else $error("Write started while device full");

  rd_level_a: assert property (
    $fell(dev_ctl.fetch_pulse_n) |-> $past(sts_s.no_data_flag_n))
    else $error("Read started while device empty");

endmodule : fhc_host

// ### verilog/fhc_pkg.sv
package fhc_pkg;

  // ==========================================================
  // Word and bus geometry
  localparam int WORD_W      = 9;
  localparam int ADDR_W      = 5;
  localparam int DATA_W      = 32;
  localparam int SYNC_STAGES = 2;

  // ==========================================================
  // Device timing, slowest speed grade so any grade works
  localparam int CLK_NS      = 20;
  localparam int T_PULSE_NS  = 80;
  localparam int T_REC_NS    = 20;
  localparam int T_ACCESS_NS = 80;
  localparam int T_DS_NS     = 40;
  localparam int T_FLAG_NS   = 100;
  localparam int T_RS_NS     = 80;
  localparam int T_RSS_NS    = 80;

  localparam int PULSE_C  = (T_PULSE_NS + CLK_NS - 1) / CLK_NS;
  localparam int REC_C    = (T_REC_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACCESS_C = (T_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int DS_C     = (T_DS_NS + CLK_NS - 1) / CLK_NS;
  localparam int FLAG_C   = (T_FLAG_NS + CLK_NS - 1) / CLK_NS;
  localparam int RS_C     = (T_RS_NS + CLK_NS - 1) / CLK_NS;
  localparam int RSS_C    = (T_RSS_NS + CLK_NS - 1) / CLK_NS;

  typedef logic [3:0] fhc_cnt_t;
  localparam fhc_cnt_t CNT_STEP = 4'h1;
  // Strobe low long enough for pulse width and data setup
  localparam fhc_cnt_t WR_LOW_CYC =
    fhc_cnt_t'((PULSE_C > DS_C) ? PULSE_C : DS_C);
  // Access time plus synchroniser delay before out_bus is sampled
  localparam fhc_cnt_t RD_LOW_CYC =
    fhc_cnt_t'(((PULSE_C > ACCESS_C + SYNC_STAGES) ? PULSE_C :
                ACCESS_C + SYNC_STAGES) + 1);
  localparam fhc_cnt_t RST_LOW_CYC =
    fhc_cnt_t'((RS_C > RSS_C) ? RS_C : RSS_C);
  localparam fhc_cnt_t RT_LOW_CYC = fhc_cnt_t'(PULSE_C);
  // Flags must settle and pass the synchroniser before next decision
  localparam fhc_cnt_t REC_CYC =
    fhc_cnt_t'((REC_C > FLAG_C + SYNC_STAGES) ? REC_C :
               FLAG_C + SYNC_STAGES);

  // ==========================================================
  // Register map
  localparam logic [ADDR_W-1:0] REG_CMD    = 5'h00;
  localparam logic [ADDR_W-1:0] REG_WDATA  = 5'h04;
  localparam logic [ADDR_W-1:0] REG_RDATA  = 5'h08;
  localparam logic [ADDR_W-1:0] REG_STATUS = 5'h0C;
  localparam logic [ADDR_W-1:0] REG_CFG    = 5'h10;

  localparam int CMD_RESET  = 0;
  localparam int CMD_WRITE  = 1;
  localparam int CMD_READ   = 2;
  localparam int CMD_REPLAY = 3;
  localparam int CMD_W      = 4;

  localparam int ST_BUSY   = 0;
  localparam int ST_INIT   = 1;
  localparam int ST_NODATA = 2;
  localparam int ST_NOROOM = 3;
  localparam int ST_MID    = 4;
  localparam int ST_WR_REF = 5;
  localparam int ST_RD_REF = 6;
  localparam int ST_RT_REF = 7;
  localparam int REF_W     = 3;

  localparam int CFG_DEPTH = 0;
  localparam int CFG_FIRST = 1;
  localparam int CFG_W     = 2;
  localparam logic [CFG_W-1:0] CFG_RESET = 2'h0;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    S_IDLE, S_RST, S_WR, S_RD, S_RT, S_REC
  } fhc_state_e;

  typedef struct packed {
    logic              clear_pulse_n;
    logic              store_pulse_n;
    logic              fetch_pulse_n;
    logic              lead_or_replay_n;
    logic [WORD_W-1:0] in_bus;
  } fhc_dev_ctl_s;

  typedef struct packed {
    logic              no_data_flag_n;
    logic              no_room_flag_n;
    logic              midpoint_flag_n;
    logic [WORD_W-1:0] out_bus;
  } fhc_dev_sts_s;

  localparam fhc_dev_ctl_s CTL_IDLE = '{
    clear_pulse_n: 1'b1, store_pulse_n: 1'b1, fetch_pulse_n: 1'b1,
    lead_or_replay_n: 1'b1, in_bus: 9'h000};

endpackage : fhc_pkg

// ### verilog/fhc_sync.sv
`timescale 1ns/10ps
module fhc_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         srst,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_nxt;

  // ==========================================================
  // Two stages; first stage is read only by the second
  always_comb begin
    meta_nxt = d;
    q_nxt    = meta_r;
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      meta_r <= '0;
      q      <= '0;
    end else if (ce) begin
      meta_r <= meta_nxt;
      q      <= q_nxt;
    end
  end

endmodule : fhc_sync

// ### sim/fhc_dev_model.sv
`timescale 1ns/10ps
// ==========================================================
// Strobe-driven 1024 x 9 buffer model, single-device wiring
module fhc_dev_model #(
  parameter int ACC_NS  = 80,
  parameter int FLAG_NS = 60
) (
  input  wire fhc_pkg::fhc_dev_ctl_s ctl,
  input  wire logic                  chain_in,
  output fhc_pkg::fhc_dev_sts_s      sts,
  output int                         viol
);
  logic [8:0]  mem [1024];
  int unsigned wp;
  int unsigned rp;
  int unsigned occ;
  int unsigned avail;
  logic        depth_m;
  logic        inited;
  logic        w_ok;
  logic        r_ok;
  logic [8:0]  q;
  wire logic   nd_n;
  wire logic   nr_n;
  wire logic   mid_n;

  initial begin
    viol = 0;
    wp = 0;
    rp = 0;
    occ = 0;
    avail = 0;
    depth_m = 1'b0;
    inited = 1'b0;
    w_ok = 1'b0;
    r_ok = 1'b0;
    q = 9'h155;
  end

  // ==========================================================
  // Flags from pointer distance; midpoint flag also held high in depth mode
  assign #(FLAG_NS) nd_n  = (avail != 0);
  assign #(FLAG_NS) nr_n  = (occ != 1024);
  assign #(FLAG_NS) mid_n = depth_m | (occ < 512);
  assign sts = '{no_data_flag_n: nd_n, no_room_flag_n: nr_n,
                 midpoint_flag_n: mid_n, out_bus: q};

  // ==========================================================
  // Reset and replay
  always @(negedge ctl.clear_pulse_n) begin
    wp = 0;
    rp = 0;
    occ = 0;
    avail = 0;
  end
  always @(posedge ctl.clear_pulse_n) begin
    if (!ctl.store_pulse_n || !ctl.fetch_pulse_n) viol++;
    depth_m = chain_in;
    inited = 1'b1;
  end
  always @(negedge ctl.lead_or_replay_n) begin
    if (ctl.clear_pulse_n && !depth_m) begin
      if (!ctl.store_pulse_n || !ctl.fetch_pulse_n) viol++;
      rp = 0;
      occ = wp;
      avail = wp;
    end
  end

  // ==========================================================
  // Writes: room decided at the falling edge
  always @(negedge ctl.store_pulse_n) begin
    if (!inited || !ctl.lead_or_replay_n) viol++;
    w_ok = (occ < 1024);
    if (w_ok) occ++;
  end
  always @(posedge ctl.store_pulse_n) begin
    if (w_ok) begin
      mem[wp] = ctl.in_bus;
      wp = (wp + 1) % 1024;
      avail++;
      w_ok = 1'b0;
    end
  end

  // ==========================================================
  // Reads: released bus shows inverted junk, never a held word
  always @(negedge ctl.fetch_pulse_n) begin
    if (!inited || !ctl.lead_or_replay_n) viol++;
    r_ok = (avail != 0);
    if (r_ok) begin
      avail--;
      q <= #(ACC_NS) mem[rp];
    end
  end
  always @(posedge ctl.fetch_pulse_n) begin
    if (r_ok) begin
      q <= #5 ~mem[rp];
      rp = (rp + 1) % 1024;
      occ--;
      r_ok = 1'b0;
    end
  end
endmodule : fhc_dev_model

// ### sim/test_fhc_host.sv
`timescale 1ns/10ps
module test_fhc_host;
  logic                          ref_clk;
  logic                          srst;
  logic                          hsel;
  logic [31:0]                   haddr;
  logic [1:0]                    htrans;
  logic                          hwrite;
  logic [2:0]                    hsize;
  logic [31:0]                   hwdata;
  logic                          hreadyout;
  logic                          hresp;
  logic [31:0]                   hrdata;
  fhc_pkg::fhc_dev_ctl_s         dev_ctl;
  fhc_pkg::fhc_dev_sts_s         dev_sts;
  int                            viol;
  int                            mismatches;
  int                            checked;
  logic [31:0]                   d;

  fhc_host DUT (.ref_clk(ref_clk), .srst(srst), .ce(1'b1), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .dev_ctl(dev_ctl), .dev_sts(dev_sts));
  fhc_dev_model PEER (.ctl(dev_ctl), .chain_in(1'b0), .sts(dev_sts),
    .viol(viol));

  always #10 ref_clk = ~ref_clk;

  // ==========================================================
  // Bus and device helpers
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic bus(input logic [31:0] a, input logic w,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(negedge ref_clk); while (hreadyout !== 1'b1);
    @(posedge ref_clk);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(negedge ref_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    @(posedge ref_clk);
  endtask : bus

  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    logic [31:0] unused;
    bus({27'h0, a}, 1'b1, v, unused);
  endtask : wr

  task automatic rd(input logic [4:0] a, output logic [31:0] v);
    bus({27'h0, a}, 1'b0, 32'h0, v);
  endtask : rd

  // Busy may linger for the recovery span, so poll with a cap
  task automatic op(input logic [31:0] c);
    logic [31:0] s;
    int n;
    wr(fhc_pkg::REG_CMD, c);
    n = 0;
    do begin
      rd(fhc_pkg::REG_STATUS, s);
      n++;
    end while (s[0] !== 1'b0 && n < 60);
    if (s[0] !== 1'b0) mismatches++;
  endtask : op

  task automatic st_chk(input logic [6:0] e);
    logic [31:0] s;
    rd(fhc_pkg::REG_STATUS, s);
    chk("status", s, {24'h0, e, 1'b0});
  endtask : st_chk

  task automatic do_wr(input logic [8:0] v);
    wr(fhc_pkg::REG_WDATA, {23'h0, v});
    op(32'h1 << fhc_pkg::CMD_WRITE);
  endtask : do_wr

  task automatic do_rd(output logic [31:0] v);
    op(32'h1 << fhc_pkg::CMD_READ);
    rd(fhc_pkg::REG_RDATA, v);
  endtask : do_rd

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  // Full fill and drain take roughly 50k cycles
  initial begin
    repeat (90000) @(posedge ref_clk);
    mismatches++;
    test_done();
  end

  // ==========================================================
  // Main sequence
  initial begin
    ref_clk = 1'b0;
    srst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    mismatches = 0;
    checked = 0;
    repeat (2) @(posedge ref_clk);
    srst <= 1'b0;
    op(32'h0);
    st_chk(7'h0D);
    op(32'h1 << fhc_pkg::CMD_READ);
    st_chk(7'h2D);
    wr(fhc_pkg::REG_STATUS, 32'h40);
    for (int i = 0; i < 1024; i++) begin
      do_wr(i[8:0] ^ 9'h0A5);
      if (i == 0) st_chk(7'h0F);
      if (i == 510) st_chk(7'h0F);
      if (i == 511) st_chk(7'h07);
      if (i == 1023) st_chk(7'h03);
    end
    do_wr(9'h1FF);
    st_chk(7'h13);
    wr(fhc_pkg::REG_STATUS, 32'h20);
    for (int i = 0; i < 1024; i++) begin
      do_rd(d);
      chk("rdata", d, {23'h0, i[8:0] ^ 9'h0A5});
      if (i == 0) st_chk(7'h07);
      if (i == 511) st_chk(7'h07);
      if (i == 512) st_chk(7'h0F);
    end
    st_chk(7'h0D);
    for (int i = 1; i < 4; i++) do_wr(9'h100 + 9'(i));
    do_rd(d);
    chk("wrap", d, 32'h101);
    do_rd(d);
    op(32'h1 << fhc_pkg::CMD_REPLAY);
    st_chk(7'h0F);
    for (int i = 1; i < 4; i++) begin
      do_rd(d);
      chk("replay", d, 32'h100 + 32'(i));
    end
    wr(fhc_pkg::REG_CFG, 32'h3);
    // Mode is latched only by a reset cycle
    op(32'h1 << fhc_pkg::CMD_RESET);
    do_wr(9'h0AA);
    do_wr(9'h0BB);
    do_rd(d);
    op(32'h1 << fhc_pkg::CMD_REPLAY);
    st_chk(7'h4F);
    do_rd(d);
    chk("no_rewind", d, 32'h0BB);
    wr(fhc_pkg::REG_STATUS, 32'h80);
    wr(fhc_pkg::REG_CFG, 32'h0);
    do_wr(9'h055);
    op(32'h1 << fhc_pkg::CMD_RESET);
    st_chk(7'h0D);
    rd(5'h14, d);
    chk("unmapped", d, 32'h0);
    rd(fhc_pkg::REG_CMD, d);
    chk("cmd_read", d, 32'h0);
    rd(fhc_pkg::REG_WDATA, d);
    chk("wdata", d, 32'h055);
    chk("hresp", {31'h0, hresp}, 32'h0);
    chk("pin_order", 32'(viol), 32'h0);
    test_done();
  end
endmodule : test_fhc_host
